// ==== src/busy_sequencer.sv ====
/*
 * Self-clearing busy sequencer: a start pulse makes it walk COUNT addresses,
 * one per clock, with a write strobe, and drop busy after the last one.
 * Assumes start comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module busy_sequencer #(
	parameter int unsigned COUNT  = 4,
	parameter int unsigned ADDR_W = 8
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              start,
	output logic                   busy,
	output logic                   wipeWrite,
	output logic [ADDR_W-1:0]      wipeAddr
);
	typedef struct packed {
		logic              busy;
		logic              write;
		logic [ADDR_W-1:0] addr;
	} seq_state_t;

	localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(COUNT - 1);

	seq_state_t st_reg;
	seq_state_t st_next;

	// Starts only when idle, then steps the address until the last word.
	always_comb begin
		st_next = st_reg;
		if (!st_reg.busy) begin
			if (start) begin
				st_next.busy  = 1'b1;
				st_next.write = 1'b1;
				st_next.addr  = '0;
			end
		end else if (st_reg.addr == LAST_ADDR) begin
			st_next.busy  = 1'b0;
			st_next.write = 1'b0;
		end else begin
			st_next.addr = st_reg.addr + 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy      = st_reg.busy;
	assign wipeWrite = st_reg.write;
	assign wipeAddr  = st_reg.addr;

	AST_WIPE_STEP: assert property (@(posedge clock) disable iff (!rst_n)
		(st_reg.busy && st_reg.addr != LAST_ADDR) |=>
		(st_reg.busy && st_reg.write && st_reg.addr == ADDR_W'($past(st_reg.addr) + 1'b1)))
		else $error("Clear engine did not step to the next word.");

	AST_WIPE_END: assert property (@(posedge clock) disable iff (!rst_n)
		(st_reg.busy && st_reg.addr == LAST_ADDR) |=> (!st_reg.busy && !st_reg.write))
		else $error("Clear engine did not finish after the last word.");

	AST_WIPE_START: assert property (@(posedge clock) disable iff (!rst_n)
		(!st_reg.busy && start) |=> (st_reg.busy && st_reg.addr == '0))
		else $error("Clear engine did not start at word zero.");

endmodule
`default_nettype wire

// ==== src/memory_ctrl_pkg.sv ====
/*
 * Constants shared by the memory control, status and peripheral reset bank.
 * Assumes a 32-bit APB register port with 12 bits of byte address decoded.
 */
package memory_ctrl_pkg;

	// APB address and data widths.
	localparam int unsigned APB_ADDR_W = 12;
	localparam int unsigned APB_DATA_W = 32;

	// Register byte offsets.
	localparam logic [11:0] MEM_CLOCK_CONTROL_OFS    = 12'h028;
	localparam logic [11:0] MEM_ZEROIZE_CONTROL_OFS  = 12'h02c;
	localparam logic [11:0] SYSTEM_STATUS_FLAGS_OFS  = 12'h040;
	localparam logic [11:0] PERIPH_RESET_SECOND_OFS  = 12'h044;

	// Memory clock control fields.
	localparam int unsigned LIGHT_SLEEP_BIT  = 16;
	localparam int unsigned WAIT_STATES_LSB  = 0;
	localparam int unsigned WAIT_STATES_W    = 3;
	localparam logic [2:0]  WAIT_STATES_RST  = 3'h5;
	localparam logic        LIGHT_SLEEP_RST  = 1'b0;

	// Zeroization control: bits 13..8 caches and special RAMs, 6..0 RAM banks.
	localparam int unsigned ZERO_W    = 14;
	localparam logic [13:0] ZERO_MASK = 14'h3f7f;
	localparam int unsigned RAM_BANKS = 7;

	// Peripheral reset bits: 16, 15 and 10 down to 4.
	localparam int unsigned RESET_W    = 17;
	localparam logic [16:0] RESET_MASK = 17'h187f0;

	// System status flag positions.
	localparam int unsigned STAT_CACHE_FAULT_BIT = 5;
	localparam int unsigned STAT_CODE_ERROR_BIT  = 1;
	localparam int unsigned STAT_DEBUG_LOCK_BIT  = 0;

	// Clear engine address width and length of a peripheral reset pulse.
	localparam int unsigned WIPE_ADDR_W         = 16;
	localparam int unsigned RESET_ADDR_W        = 8;
	localparam int unsigned PERIPH_RESET_CYCLES = 4;

endpackage

// ==== src/memory_ctrl_status_reset_regs.sv ====
/*
 * Memory clock control, memory zeroization, system status flags and second
 * peripheral reset registers behind an APB slave with one wait state.
 * Assumes status inputs come from other domains and code read requests and
 * the APB master run on the same clock.
 */
// Added by the designer: the APB register port.
// Functional notes
// - Bank 0 light sleep keeps data but blocks all bank 0 access.
// - Code reads get as many wait cycles as the field holds; zero invalid.
// - Writing 1 to a bank clear bit zeroes every word of that bank.
// - Bits 9 and 8 clear the two 16KB instruction cache memories.
// - Bit 11 clears external cache tags, bit 10 its data memory.
// - Bit 12 clears crypto working memory, bit 13 the USB FIFO memory.
// - A clear bit reads 1 while running and returns to 0 when done.
// - Status bit 5 shows an external memory cache fault.
// - Status bit 1 shows a code integrity error on the flash link.
// - Status bit 0 shows debug lock: 1 locked, 0 unlocked.
// - Writing 1 resets a peripheral; bit reads 1 until reset completes.
// - Bit 15 returns the serial RAM peripheral to power-on state.
// - A reset bit reading 0 means done or idle; writing 0 does nothing.
// - Reset bits 16, 15 and 10 down to 4 map to their peripherals.
`timescale 1ns/1ps
`default_nettype none
module memory_ctrl_status_reset_regs
	import memory_ctrl_pkg::*;
#(
	parameter int unsigned CLEAR_WORDS [ZERO_W] = '{8192, 16384, 8192, 32768, 65536, 65536,
		65536, 1, 4096, 4096, 256, 256, 256, 256},
	parameter int unsigned RESET_CYCLES = PERIPH_RESET_CYCLES
) (
	input  wire logic                        clock,
	input  wire logic                        rst_n,
	input  wire logic [APB_ADDR_W-1:0]       paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [APB_DATA_W-1:0]       pwdata,
	output logic [APB_DATA_W-1:0]            prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        extCacheFault,
	input  wire logic                        codeIntegrityError,
	input  wire logic                        debugLocked,
	input  wire logic                        codeReadReq,
	output logic                             codeReadGo,
	output logic [2:0]                       flashWaitStates,
	output logic [RAM_BANKS-1:0]             ramAccessBlock,
	output logic [ZERO_W-1:0]                memClearWrite,
	output logic [ZERO_W*WIPE_ADDR_W-1:0]    memClearAddr,
	output logic [RESET_W-1:0]               periphReset
);
	typedef struct packed {
		logic                  lightSleep;
		logic [2:0]            waitStates;
		logic [2:0]            waitCnt;
		logic                  readGo;
		logic [RAM_BANKS-1:0]  accessBlock;
		logic [2:0]            statSync1;
		logic [2:0]            statSync2;
		logic                  ready;
		logic                  slvErr;
		logic [APB_DATA_W-1:0] rdata;
	} ctrl_state_t;

	ctrl_state_t          st_reg;
	ctrl_state_t          st_next;
	logic                 commit;
	logic                 writeCommit;
	logic                 mapped;
	logic [ZERO_W-1:0]    zeroStart;
	logic [ZERO_W-1:0]    zeroBusy;
	logic [RESET_W-1:0]   resetStart;
	logic [RESET_W-1:0]   resetBusy;

	// A transfer takes effect at the edge where pready is sampled high.
	assign commit      = psel & penable & st_reg.ready;
	assign writeCommit = commit & pwrite;
	assign mapped      = (paddr == MEM_CLOCK_CONTROL_OFS) || (paddr == MEM_ZEROIZE_CONTROL_OFS) ||
		(paddr == SYSTEM_STATUS_FLAGS_OFS) || (paddr == PERIPH_RESET_SECOND_OFS);

	// Start pulses: only written ones on implemented, idle bits start anything.
	always_comb begin
		zeroStart  = '0;
		resetStart = '0;
		if (writeCommit && paddr == MEM_ZEROIZE_CONTROL_OFS) begin
			zeroStart = pwdata[ZERO_W-1:0] & ZERO_MASK & ~zeroBusy;
		end
		if (writeCommit && paddr == PERIPH_RESET_SECOND_OFS) begin
			resetStart = pwdata[RESET_W-1:0] & RESET_MASK & ~resetBusy;
		end
	end

	// One clear engine per implemented zeroization bit.
	for (genvar b = 0; b < ZERO_W; b++) begin : gZero
		if (ZERO_MASK[b]) begin : gOn
			busy_sequencer #(
				.COUNT  (CLEAR_WORDS[b]),
				.ADDR_W (WIPE_ADDR_W)
			) uWipe (
				.clock     (clock),
				.rst_n     (rst_n),
				.start     (zeroStart[b]),
				.busy      (zeroBusy[b]),
				.wipeWrite (memClearWrite[b]),
				.wipeAddr  (memClearAddr[b*WIPE_ADDR_W +: WIPE_ADDR_W])
			);
		end else begin : gOff
			assign zeroBusy[b]                                   = 1'b0;
			assign memClearWrite[b]                              = 1'b0;
			assign memClearAddr[b*WIPE_ADDR_W +: WIPE_ADDR_W]    = '0;
		end
	end

	// One reset pulse engine per implemented peripheral reset bit.
	for (genvar r = 0; r < RESET_W; r++) begin : gReset
		if (RESET_MASK[r]) begin : gOn
			busy_sequencer #(
				.COUNT  (RESET_CYCLES),
				.ADDR_W (RESET_ADDR_W)
			) uPulse (
				.clock     (clock),
				.rst_n     (rst_n),
				.start     (resetStart[r]),
				.busy      (resetBusy[r]),
				.wipeWrite (),
				.wipeAddr  ()
			);
		end else begin : gOff
			assign resetBusy[r] = 1'b0;
		end
	end

	// Register file, status synchroniser, wait counter and APB answer.
	always_comb begin
		st_next           = st_reg;
		st_next.readGo    = 1'b0;
		st_next.statSync1 = {extCacheFault, codeIntegrityError, debugLocked};
		st_next.statSync2 = st_reg.statSync1;
		// Register writes; reserved bits are dropped.
		if (writeCommit && paddr == MEM_CLOCK_CONTROL_OFS) begin
			st_next.lightSleep = pwdata[LIGHT_SLEEP_BIT];
			if (pwdata[WAIT_STATES_LSB +: WAIT_STATES_W] != 3'h0) begin
				st_next.waitStates = pwdata[WAIT_STATES_LSB +: WAIT_STATES_W];
			end
		end
		// Wait states on each code read requested while waitCnt is zero; requests during a count are dropped.
		if (st_reg.waitCnt == 3'h0) begin
			if (codeReadReq) begin
				st_next.waitCnt = st_reg.waitStates;
			end
		end else begin
			st_next.waitCnt = st_reg.waitCnt - 3'h1;
			if (st_reg.waitCnt == 3'h1) begin
				st_next.readGo = 1'b1;
			end
		end
		// Bank blocking by light sleep or a running clear.
		st_next.accessBlock    = zeroBusy[RAM_BANKS-1:0] | zeroStart[RAM_BANKS-1:0];
		st_next.accessBlock[0] = st_next.accessBlock[0] | st_next.lightSleep;
		// APB: one wait cycle, then answer with data and error.
		st_next.ready = psel & penable & ~st_reg.ready;
		if (psel && penable && !st_reg.ready) begin
			st_next.slvErr = ~mapped;
			st_next.rdata  = '0;
			case (paddr)
				MEM_CLOCK_CONTROL_OFS: begin
					st_next.rdata[LIGHT_SLEEP_BIT]                 = st_reg.lightSleep;
					st_next.rdata[WAIT_STATES_LSB +: WAIT_STATES_W] = st_reg.waitStates;
				end
				MEM_ZEROIZE_CONTROL_OFS: begin
					st_next.rdata[ZERO_W-1:0] = zeroBusy;
				end
				SYSTEM_STATUS_FLAGS_OFS: begin
					st_next.rdata[STAT_CACHE_FAULT_BIT] = st_reg.statSync2[2];
					st_next.rdata[STAT_CODE_ERROR_BIT]  = st_reg.statSync2[1];
					st_next.rdata[STAT_DEBUG_LOCK_BIT]  = st_reg.statSync2[0];
				end
				PERIPH_RESET_SECOND_OFS: begin
					st_next.rdata[RESET_W-1:0] = resetBusy;
				end
				default: begin
					st_next.rdata = '0;
				end
			endcase
		end else begin
			st_next.slvErr = 1'b0;
		end
	end

	// State register with reset values.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg            <= '0;
			st_reg.lightSleep <= LIGHT_SLEEP_RST;
			st_reg.waitStates <= WAIT_STATES_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata          = st_reg.rdata;
	assign pready          = st_reg.ready;
	assign pslverr         = st_reg.slvErr;
	assign codeReadGo      = st_reg.readGo;
	assign flashWaitStates = st_reg.waitStates;
	assign ramAccessBlock  = st_reg.accessBlock;
	assign periphReset     = resetBusy;

	AST_LIGHT_SLEEP_BLOCK: assert property (@(posedge clock) disable iff (!rst_n)
		st_reg.lightSleep |-> ramAccessBlock[0])
		else $error("Bank 0 accessible while in light sleep.");

	AST_WAIT_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
		(st_reg.waitCnt == 3'h0 && codeReadReq) |=> (st_reg.waitCnt == $past(st_reg.waitStates)))
		else $error("Wait counter not loaded from the wait-state field.");

	AST_WAIT_GO: assert property (@(posedge clock) disable iff (!rst_n)
		(st_reg.waitCnt == 3'h1) |=> (codeReadGo && st_reg.waitCnt == 3'h0) ##1 !codeReadGo)
		else $error("Code read released at the wrong cycle.");

	AST_WAIT_NONZERO: assert property (@(posedge clock) disable iff (!rst_n)
		flashWaitStates != 3'h0)
		else $error("Wait-state field holds the invalid value zero.");

	AST_ZERO_BUSY: assert property (@(posedge clock) disable iff (!rst_n)
		(|zeroStart) |=> ((zeroBusy & $past(zeroStart)) == $past(zeroStart)))
		else $error("Clear bit did not read busy after its start.");

	AST_ZERO_READBACK: assert property (@(posedge clock) disable iff (!rst_n)
		(psel && penable && !pready && !pwrite && paddr == MEM_ZEROIZE_CONTROL_OFS) |=>
		(pready && prdata == {18'h0, $past(zeroBusy)}))
		else $error("Zeroization readback differs from engine state.");

	// Pulse length follows RESET_CYCLES and is checked inside each sequencer.
	AST_RESET_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
		(periphReset & ~$past(periphReset)) == $past(resetStart))
		else $error("Peripheral reset rose without a matching start.");

	AST_RESET_NEEDS_ONE: assert property (@(posedge clock) disable iff (!rst_n)
		(resetStart & ~pwdata[RESET_W-1:0]) == 17'h0 && (resetStart & ~RESET_MASK) == 17'h0)
		else $error("Reset started without a written one.");

	AST_STATUS_READ: assert property (@(posedge clock) disable iff (!rst_n)
		(psel && penable && !pready && !pwrite && paddr == SYSTEM_STATUS_FLAGS_OFS) |=>
		(prdata == {26'h0, $past(st_reg.statSync2[2]), 3'h0,
		$past(st_reg.statSync2[1]), $past(st_reg.statSync2[0])}))
		else $error("Status flags read back wrongly.");

	AST_CLEAR_BLOCK: assert property (@(posedge clock) disable iff (!rst_n)
		(zeroBusy[RAM_BANKS-1:0] & ~ramAccessBlock) == 7'h0)
		else $error("Bank accessible while its clear is running.");

	AST_UNMAPPED: assert property (@(posedge clock) disable iff (!rst_n)
		(psel && penable && !pready && !mapped) |=> (pready && pslverr && prdata == 32'h0))
		else $error("Unmapped access not answered with an error.");

	// Register writes, readback and start masks as seen from the bus side.
	AST_WAIT_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
		(writeCommit && paddr == MEM_CLOCK_CONTROL_OFS &&
		pwdata[WAIT_STATES_LSB +: WAIT_STATES_W] != 3'h0) |=>
		(flashWaitStates == $past(pwdata[WAIT_STATES_LSB +: WAIT_STATES_W])))
		else $error("Wait-state field did not take the written count.");

	AST_WAIT_ZERO_KEPT: assert property (@(posedge clock) disable iff (!rst_n)
		(writeCommit && paddr == MEM_CLOCK_CONTROL_OFS &&
		pwdata[WAIT_STATES_LSB +: WAIT_STATES_W] == 3'h0) |=> $stable(flashWaitStates))
		else $error("Wait-state field changed on a written zero.");

	AST_SLEEP_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
		(writeCommit && paddr == MEM_CLOCK_CONTROL_OFS) |=>
		(st_reg.lightSleep == $past(pwdata[LIGHT_SLEEP_BIT])))
		else $error("Light sleep bit did not take the written value.");

	AST_CLOCK_READBACK: assert property (@(posedge clock) disable iff (!rst_n)
		(psel && penable && !pready && !pwrite && paddr == MEM_CLOCK_CONTROL_OFS) |=>
		(pready && prdata == {15'h0, $past(st_reg.lightSleep), 13'h0,
		$past(st_reg.waitStates)}))
		else $error("Clock control register read back wrongly.");

	AST_RESET_READBACK: assert property (@(posedge clock) disable iff (!rst_n)
		(psel && penable && !pready && !pwrite && paddr == PERIPH_RESET_SECOND_OFS) |=>
		(pready && prdata == {15'h0, $past(resetBusy)}))
		else $error("Reset register readback differs from pulse state.");

	AST_MAPPED_NO_ERROR: assert property (@(posedge clock) disable iff (!rst_n)
		(psel && penable && !pready && mapped) |=> (pready && !pslverr))
		else $error("Mapped access answered with an error.");

	AST_ZERO_NEEDS_ONE: assert property (@(posedge clock) disable iff (!rst_n)
		(zeroStart & ~pwdata[ZERO_W-1:0]) == 14'h0 && (zeroStart & ~ZERO_MASK) == 14'h0)
		else $error("Clear started without a written one.");

	AST_ZERO_IDLE_BITS: assert property (@(posedge clock) disable iff (!rst_n)
		((zeroBusy | memClearWrite) & ~ZERO_MASK) == 14'h0)
		else $error("Reserved zeroization bit shows activity.");

	AST_RESET_IDLE_BITS: assert property (@(posedge clock) disable iff (!rst_n)
		(periphReset & ~RESET_MASK) == 17'h0)
		else $error("Reserved reset bit shows activity.");

	AST_BLOCK_RELEASE: assert property (@(posedge clock) disable iff (!rst_n)
		(ramAccessBlock[RAM_BANKS-1:1] &
		~($past(zeroBusy[RAM_BANKS-1:1]) | $past(zeroStart[RAM_BANKS-1:1]))) == 6'h0)
		else $error("Bank blocked with no clear running.");

	AST_GO_NEEDS_COUNT: assert property (@(posedge clock) disable iff (!rst_n)
		codeReadGo |-> ($past(st_reg.waitCnt) == 3'h1))
		else $error("Code read released before its wait states ran out.");

endmodule
`default_nettype wire

// ==== test/test_memory_ctrl_status_reset_regs.sv ====
/*
 * Self-checking bench for the memory control, zeroization, status and
 * peripheral reset register bank, driven over APB with seeded random stimulus.
 * Assumes one 10 MHz clock and the one-wait-state APB slave of the design.
 */
`timescale 1ns/1ps
`default_nettype none
module test_memory_ctrl_status_reset_regs
	import memory_ctrl_pkg::*;
;
	localparam int unsigned WORDS [ZERO_W] = '{6, 7, 8, 9, 10, 11, 12, 1, 6, 7, 8, 9, 10, 11};
	localparam int unsigned RST_CYC = 8;
	logic                         clock, rst_n, psel, penable, pwrite, codeReadReq;
	logic [11:0]                  paddr;
	logic [31:0]                  pwdata, prdata, rdata;
	logic                         pready, pslverr, rerr, codeReadGo;
	logic                         extCacheFault, codeIntegrityError, debugLocked;
	logic [2:0]                   flashWaitStates;
	logic [RAM_BANKS-1:0]         ramAccessBlock;
	logic [ZERO_W-1:0]            memClearWrite;
	logic [ZERO_W*WIPE_ADDR_W-1:0] memClearAddr;
	logic [RESET_W-1:0]           periphReset;
	int                           error_cnt, n_checks, seed, addrBad, blkBad;
	int                           zc [ZERO_W];
	int                           rc [RESET_W];

	memory_ctrl_status_reset_regs #(.CLEAR_WORDS(WORDS), .RESET_CYCLES(RST_CYC)) i_dut (
		.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .extCacheFault(extCacheFault),
		.codeIntegrityError(codeIntegrityError), .debugLocked(debugLocked),
		.codeReadReq(codeReadReq), .codeReadGo(codeReadGo),
		.flashWaitStates(flashWaitStates), .ramAccessBlock(ramAccessBlock),
		.memClearWrite(memClearWrite), .memClearAddr(memClearAddr),
		.periphReset(periphReset));

	// Free-running system clock, 100 ns period.
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Counts engine and reset cycles and checks wipe addresses and bank blocking.
	always @(posedge clock) begin
		for (int b = 0; b < ZERO_W; b++) begin
			if (memClearWrite[b] === 1'b1) begin
				if (memClearAddr[b*WIPE_ADDR_W+:WIPE_ADDR_W] !== zc[b][15:0]) addrBad++;
				if (b < RAM_BANKS && ramAccessBlock[b] !== 1'b1) blkBad++;
				zc[b]++;
			end
		end
		for (int b = 0; b < RESET_W; b++) begin
			if (periphReset[b] === 1'b1) rc[b]++;
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Compares a design value with its expected value.
	task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	// Compares a bench count with its expected count.
	task automatic check_cnt(input string what, input int e, input int g);
		n_checks++;
		if (g != e) begin
			error_cnt++;
			$display("mismatch %s expected %0d seen %0d", what, e, g);
		end
	endtask

	// One APB transfer; holds the request until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clock);
			t++;
		end while (pready !== 1'b1 && t < 20);
		rdata = prdata;
		rerr = pslverr;
		if (t >= 20) check_cnt("pready wait", 0, t);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reads a register and compares data and error response.
	task automatic rd(input string what, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check_word(what, e, rdata);
		check_word("pslverr", 32'h0, {31'h0, rerr});
	endtask

	// Starts zeroize or reset bits, watches them read busy, then drop with exact lengths.
	task automatic pulse_run(input logic zero, input logic [31:0] m);
		logic [11:0] a;
		logic [31:0] live;
		int          n;
		a = zero ? MEM_ZEROIZE_CONTROL_OFS : PERIPH_RESET_SECOND_OFS;
		live = m & (zero ? {18'h0, ZERO_MASK} : {15'h0, RESET_MASK});
		foreach (zc[b]) zc[b] = 0;
		foreach (rc[b]) rc[b] = 0;
		apb(1'b1, a, m);
		rd("busy bits", a, live);
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while (rdata !== 32'h0 && n < 40);
		check_word("self clear", 32'h0, rdata);
		for (int b = 0; b < ZERO_W; b++) begin
			check_cnt("wipe words", (zero && live[b]) ? WORDS[b] : 0, zc[b]);
		end
		for (int b = 0; b < RESET_W; b++) begin
			check_cnt("reset cycles", (!zero && live[b]) ? RST_CYC : 0, rc[b]);
		end
	endtask

	// Issues one code read and measures the delay to the grant pulse.
	task automatic code_read(input logic [2:0] fws);
		int n;
		@(posedge clock);
		codeReadReq <= 1'b1;
		@(posedge clock);
		codeReadReq <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (codeReadGo !== 1'b1 && n < 20);
		check_cnt("codeReadGo delay", fws + 1, n);
		@(posedge clock);
		check_word("codeReadGo width", 32'h0, {31'h0, codeReadGo});
	endtask

	// Cuts a hang short.
	initial begin
		#(100 * 40000);
		error_cnt++;
		print_verdict();
	end

	// Main sequence.
	initial begin
		logic [2:0]  f;
		logic [31:0] r;
		seed = 32'h1629;
		{error_cnt, n_checks, addrBad, blkBad} = '0;
		{rst_n, psel, penable, pwrite, codeReadReq} = '0;
		{extCacheFault, codeIntegrityError, debugLocked} = '0;
		paddr = '0;
		pwdata = '0;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		check_word("flashWaitStates reset", 32'h5, {29'h0, flashWaitStates});
		rd("clock ctrl reset", MEM_CLOCK_CONTROL_OFS, 32'h5);
		rd("zeroize reset", MEM_ZEROIZE_CONTROL_OFS, 32'h0);
		rd("status reset", SYSTEM_STATUS_FLAGS_OFS, 32'h0);
		rd("reset reg reset", PERIPH_RESET_SECOND_OFS, 32'h0);
		apb(1'b0, 12'h030, 32'h0);
		check_word("unmapped err", 32'h1, {31'h0, rerr});
		check_word("unmapped data", 32'h0, rdata);
		apb(1'b1, 12'h030, 32'hffffffff);
		check_word("unmapped write err", 32'h1, {31'h0, rerr});
		// Light sleep with reserved bits written, then a zero wait count refused.
		apb(1'b1, MEM_CLOCK_CONTROL_OFS, 32'h0001fffb);
		rd("clock ctrl sleep", MEM_CLOCK_CONTROL_OFS, 32'h00010003);
		check_word("bank0 blocked", 32'h1, {31'h0, ramAccessBlock[0]});
		apb(1'b1, MEM_CLOCK_CONTROL_OFS, 32'h0);
		rd("clock ctrl wake", MEM_CLOCK_CONTROL_OFS, 32'h3);
		check_word("bank0 free", 32'h0, {31'h0, ramAccessBlock[0]});
		// Random legal wait counts, the boundaries 1 and 7 included.
		for (int i = 0; i < 6; i++) begin
			f = (i == 0) ? 3'h1 : (i == 1) ? 3'h7 : 3'(($random(seed) & 32'h7) % 7 + 1);
			apb(1'b1, MEM_CLOCK_CONTROL_OFS, {29'h0, f});
			@(posedge clock);
			check_word("flashWaitStates", {29'h0, f}, {29'h0, flashWaitStates});
			code_read(f);
		end
		// Every zeroize bit alone, then all at once.
		for (int b = 0; b < 15; b++) pulse_run(1'b1, 32'h1 << b);
		pulse_run(1'b1, 32'hffffffff);
		check_cnt("wipe address order", 0, addrBad);
		check_cnt("bank held off", 0, blkBad);
		// Peripheral resets: every bit, none, and random sets.
		for (int b = 0; b < RESET_W; b++) pulse_run(1'b0, 32'h1 << b);
		pulse_run(1'b0, 32'h0);
		pulse_run(1'b0, 32'hffffffff);
		repeat (3) pulse_run(1'b0, $random(seed));
		// Random status inputs; writes to the read-only register are ignored.
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			extCacheFault <= r[0];
			codeIntegrityError <= r[1];
			debugLocked <= r[2];
			repeat (4) @(posedge clock);
			apb(1'b1, SYSTEM_STATUS_FLAGS_OFS, 32'hffffffff);
			rd("status flags", SYSTEM_STATUS_FLAGS_OFS, {26'h0, r[0], 3'h0, r[1], r[2]});
		end
		print_verdict();
	end
endmodule
`default_nettype wire
